// ===== rtl/ewq_egress.sv
/*
  Egress port: per-priority weighted round-robin, strict priority,
  watermark admission, eight-packet output queue, link transmit.
  Assumes sources, link partner and power-down logic share core_clk_i.
*/
// The strobed register port and the register offsets were chosen for this implementation.
// Overview of operation
// - Four separate round-robin arbiters, one per packet priority.
// - Round-robin serves requesters in turn; pointer starts at input zero.
// - Weighting off: multicast is one ordinary slot; counter ignored.
// - Weighting on: counter, preferred type and weight pick multicast or unicast.
// - Preferred-type bit 0 favours multicast, 1 favours unicast.
// - Favoured sends count up; at weight, one non-favoured sent, counter cleared.
// - Missing type yields its slot; favoured fill does not consume non-favoured turn.
// - Weight zero gives non-favoured type every slot when both wait.
// - Output queue holds at most eight packets.
// - Full queue is signalled to ingress, which then holds its packets.
// - Priorities 0-2 need free above watermark; priority 3 needs one free.
// - Watermarks reset to 3, 2, 1 for priorities 0, 1, 2.
// - Without retry, packets leave in arrival order.
// - After retry, oldest packet of highest queued priority goes next.
// - Powered down: flush queue, keep accepting, discard silently.
// - Strict priority: higher priority accepted before any lower one.
`timescale 1ns/100ps
module ewq_egress
  import ewq_pkg::*;
#(
  parameter int N_IN = 16
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_i,
  input  wire logic [ADR_W-1:0]     reg_addr_i,
  input  wire logic [DAT_W-1:0]     reg_wdata_i,
  input  wire logic                 reg_we_i,
  input  wire logic                 reg_re_i,
  output logic      [DAT_W-1:0]     reg_rdata_o,
  input  wire logic [N_IN:0]        src_req_i,
  input  wire ewq_pkt_t [N_IN:0]    src_pkt_i,
  output logic      [N_IN:0]        src_grant_o,
  output logic                      queue_full_o,
  input  wire logic                 port_power_down_i,
  output logic                      tx_valid_o,
  output ewq_pkt_t                  tx_pkt_o,
  input  wire logic                 tx_ready_i,
  input  wire logic                 tx_ack_i,
  input  wire logic                 tx_retry_i
);
  localparam int NS = N_IN + 1;
  localparam int IW = $clog2(NS);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ewq_wrr_t          wrr_r    [PRIO_N];
  logic [WM_W-1:0]   wm_r     [3];
  logic [IW-1:0]     ptr_r    [PRIO_N];
  logic [WGT_W-1:0]  cnt_r    [PRIO_N];
  ewq_pkt_t          q_r      [QDEPTH];
  logic [QCNT_W-1:0] qcnt_r;
  ewq_tx_t           tx_st_r;
  logic [2:0]        tx_idx_r;
  logic              retry_r;
  logic              tx_valid_r;
  ewq_pkt_t          tx_pkt_r;
  logic [DAT_W-1:0]  rdata_r;

  logic [QCNT_W-1:0] free_cnt;
  logic [NS-1:0]     rq       [PRIO_N];
  logic              pk_ok    [PRIO_N];
  logic [IW-1:0]     pk_idx   [PRIO_N];
  logic              cnt_inc  [PRIO_N];
  logic              cnt_clr  [PRIO_N];
  logic              take_non [PRIO_N];
  logic              both_av  [PRIO_N];
  logic              adm      [PRIO_N];
  logic              acc;
  logic [1:0]        acc_p;
  logic [IW-1:0]     acc_idx;
  ewq_pkt_t          acc_pkt;
  logic              retire;
  logic [2:0]        sel;
  logic [1:0]        best;
  logic              pd;

  assign pd       = port_power_down_i;
  assign free_cnt = QCNT_W'(QDEPTH) - qcnt_r;
  assign retire   = (tx_st_r == TX_WAIT) && tx_ack_i && !pd;

  // First requester at or after the pointer, cyclically
  function automatic logic [IW:0] rr_pick(input logic [NS-1:0] req, input logic [IW-1:0] ptr);
    logic [IW:0] r;
    int          k;
    r = '0;
    for (int i = NS - 1; i >= 0; i--) begin
      k = (int'(ptr) + i) % NS;
      if (req[k]) begin
        r = {1'b1, IW'(k)};
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Per-priority weighted round-robin
  // ----------------------------------------------------------------
  always_comb begin
    logic [IW:0] all_pk;
    logic [IW:0] uc_pk;
    logic        fav_mc;
    logic        fav_av;
    logic        non_av;
    logic        turn_non;
    logic        take_fav;
    logic        mc_win;
    all_pk = '0;
    uc_pk  = '0;
    fav_mc = 1'b0;
    fav_av = 1'b0;
    non_av = 1'b0;
    turn_non = 1'b0;
    take_fav = 1'b0;
    mc_win = 1'b0;
    for (int p = 0; p < PRIO_N; p++) begin
      for (int s = 0; s < NS; s++) begin
        rq[p][s] = src_req_i[s] && (src_pkt_i[s].prio == 2'(p));
      end
      all_pk = rr_pick(rq[p], ptr_r[p]);
      uc_pk  = rr_pick(rq[p] & ~(NS'(1) << N_IN), ptr_r[p]);
      fav_mc   = !wrr_r[p].uc;
      fav_av   = fav_mc ? rq[p][N_IN] : uc_pk[IW];
      non_av   = fav_mc ? uc_pk[IW] : rq[p][N_IN];
      turn_non = (cnt_r[p] == wrr_r[p].wgt);
      both_av[p] = fav_av && non_av;
      // weight zero always at non-favoured turn
      take_non[p] = non_av && (turn_non || !fav_av);
      take_fav    = !take_non[p] && fav_av;
      mc_win      = take_fav ? fav_mc : !fav_mc;
      if (wrr_r[p].en) begin
        pk_ok[p]   = take_non[p] || take_fav;
        pk_idx[p]  = mc_win ? IW'(N_IN) : uc_pk[IW-1:0];
        // count favoured, clear after non-favoured turn
        cnt_inc[p] = take_fav && !turn_non;
        cnt_clr[p] = take_non[p] && turn_non;
      end else begin
        pk_ok[p]   = all_pk[IW];
        pk_idx[p]  = all_pk[IW-1:0];
        cnt_inc[p] = 1'b0;
        cnt_clr[p] = 1'b0;
      end
      if (p == PRIO_N - 1) begin
        adm[p] = pd || (free_cnt != '0);
      end else begin
        adm[p] = pd || (free_cnt > QCNT_W'(wm_r[p]));
      end
    end
  end

  // ----------------------------------------------------------------
  // Strict priority
  // ----------------------------------------------------------------
  always_comb begin
    acc     = 1'b0;
    acc_p   = '0;
    acc_idx = '0;
    for (int p = 0; p < PRIO_N; p++) begin
      if (pk_ok[p] && adm[p]) begin
        acc     = 1'b1;
        acc_p   = 2'(p);
        acc_idx = pk_idx[p];
      end
    end
    acc_pkt     = src_pkt_i[acc_idx];
    src_grant_o = acc ? (NS'(1) << acc_idx) : '0;
  end

  assign queue_full_o = (qcnt_r == QCNT_W'(QDEPTH));

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int p = 0; p < PRIO_N; p++) begin
        ptr_r[p] <= IW'(RR_PTR_RST);
        cnt_r[p] <= '0;
      end
    end else if (acc) begin
      if (!wrr_r[acc_p].en || acc_idx != IW'(N_IN)) begin
        ptr_r[acc_p] <= (acc_idx == IW'(NS - 1)) ? '0 : acc_idx + 1'b1;
      end
      if (cnt_clr[acc_p]) begin
        cnt_r[acc_p] <= '0;
      end else if (cnt_inc[acc_p]) begin
        cnt_r[acc_p] <= cnt_r[acc_p] + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output queue, kept in arrival order
  // ----------------------------------------------------------------
  // eight entries
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < QDEPTH - 1; i++) begin
      if (retire && i >= int'(tx_idx_r)) begin
        q_r[i] <= q_r[i + 1];
      end
    end
    if (acc && !pd) begin
      q_r[3'(qcnt_r - QCNT_W'(retire))] <= acc_pkt;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      qcnt_r <= '0;
    end else if (pd) begin
      qcnt_r <= '0;
    end else begin
      qcnt_r <= qcnt_r + QCNT_W'(acc) - QCNT_W'(retire);
    end
  end

  // ----------------------------------------------------------------
  // Transmit selection
  // ----------------------------------------------------------------
  always_comb begin
    sel  = '0;
    best = '0;
    if (retry_r) begin
      for (int i = QDEPTH - 1; i >= 0; i--) begin
        if (QCNT_W'(i) < qcnt_r && q_r[i].prio >= best) begin
          best = q_r[i].prio;
          sel  = 3'(i);
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_st_r    <= TX_IDLE;
      tx_idx_r   <= '0;
      tx_valid_r <= 1'b0;
      tx_pkt_r   <= '0;
      retry_r    <= 1'b0;
    end else if (pd) begin
      tx_st_r    <= TX_IDLE;
      tx_valid_r <= 1'b0;
      retry_r    <= 1'b0;
    end else begin
      unique case (tx_st_r)
        TX_IDLE: begin
          if (qcnt_r != '0) begin
            tx_idx_r   <= sel;
            tx_pkt_r   <= q_r[sel];
            tx_valid_r <= 1'b1;
            tx_st_r    <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (tx_ready_i) begin
            tx_valid_r <= 1'b0;
            tx_st_r    <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (tx_ack_i) begin
            retry_r <= 1'b0;
            tx_st_r <= TX_IDLE;
          end else if (tx_retry_i) begin
            retry_r <= 1'b1;
            tx_st_r <= TX_IDLE;
          end
        end
      endcase
    end
  end

  assign tx_valid_o = tx_valid_r;
  assign tx_pkt_o   = tx_pkt_r;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int p = 0; p < PRIO_N; p++) begin
        wrr_r[p] <= WRR_RST;
      end
      wm_r[0] <= WM0_RST;
      wm_r[1] <= WM1_RST;
      wm_r[2] <= WM2_RST;
    end else if (reg_we_i) begin
      for (int p = 0; p < PRIO_N; p++) begin
        if (reg_addr_i == OFS_WRR0 + ADR_W'(4 * p)) begin
          wrr_r[p] <= '{en: reg_wdata_i[BIT_EN], uc: reg_wdata_i[BIT_UC],
                        wgt: reg_wdata_i[WGT_LSB +: WGT_W]};
        end
      end
      if (reg_addr_i == OFS_WM) begin
        wm_r[0] <= reg_wdata_i[WM0_LSB +: WM_W];
        wm_r[1] <= reg_wdata_i[WM1_LSB +: WM_W];
        wm_r[2] <= reg_wdata_i[WM2_LSB +: WM_W];
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= '0;
      if (reg_re_i) begin
        for (int p = 0; p < PRIO_N; p++) begin
          if (reg_addr_i == OFS_WRR0 + ADR_W'(4 * p)) begin
            rdata_r[BIT_EN]               <= wrr_r[p].en;
            rdata_r[BIT_UC]               <= wrr_r[p].uc;
            rdata_r[WGT_LSB +: WGT_W]     <= wrr_r[p].wgt;
          end
        end
        if (reg_addr_i == OFS_WM) begin
          rdata_r[WM0_LSB +: WM_W] <= wm_r[0];
          rdata_r[WM1_LSB +: WM_W] <= wm_r[1];
          rdata_r[WM2_LSB +: WM_W] <= wm_r[2];
        end
        if (reg_addr_i == OFS_STAT) begin
          rdata_r[STAT_FREE +: QCNT_W] <= free_cnt;
          rdata_r[STAT_RTY]            <= retry_r;
          rdata_r[STAT_PD]             <= pd;
        end
      end
    end
  end

  assign reg_rdata_o = rdata_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_ONE_GRANT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $onehot0(src_grant_o) && (acc == (src_grant_o != '0)))
    else $error("grant not one-hot");
  AST_P3_ADMIT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    acc && acc_p == 2'd3 && !pd |-> free_cnt != '0)
    else $error("priority 3 admitted with no free buffer");
  AST_WM_ADMIT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    acc && acc_p != 2'd3 && !pd |-> free_cnt > QCNT_W'(wm_r[acc_p]))
    else $error("admission at or below watermark");
  AST_SP_TOP: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pk_ok[3] && adm[3] |-> acc && acc_p == 2'd3 && src_pkt_i[acc_idx].prio == 2'd3)
    else $error("priority 3 passed over");
  AST_FULL_STOP: assert property (@(posedge core_clk_i) disable iff (rst_i)
    queue_full_o && !pd |-> !acc ##1 qcnt_r <= QCNT_W'(QDEPTH))
    else $error("packet admitted into full queue");
  AST_FLUSH: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pd |=> qcnt_r == '0 && !tx_valid_o)
    else $error("queue not flushed while powered down");
  AST_FREE_CNT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !pd && acc && !retire |=> pd || free_cnt == $past(free_cnt) - 1'b1)
    else $error("free count did not fall on admission");
  AST_FIFO_HEAD: assert property (@(posedge core_clk_i) disable iff (rst_i)
    tx_st_r == TX_IDLE && !retry_r && !pd && qcnt_r != '0 |=> tx_idx_r == '0 && tx_valid_o)
    else $error("launch not from queue head");
  AST_WGT_ZERO: assert property (@(posedge core_clk_i) disable iff (rst_i)
    acc && wrr_r[acc_p].en && wrr_r[acc_p].wgt == '0 && both_av[acc_p] |-> take_non[acc_p])
    else $error("weight zero picked favoured type");
  AST_CNT_IDLE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    acc && !wrr_r[acc_p].en |=> cnt_r[$past(acc_p)] == $past(cnt_r[acc_p]))
    else $error("counter moved with weighting off");
  AST_RETRY_PRIO: assert property (@(posedge core_clk_i) disable iff (rst_i)
    tx_st_r == TX_IDLE && retry_r && !pd && qcnt_r != '0 |=> tx_pkt_o.prio == $past(best))
    else $error("retry did not pick highest priority");
endmodule // ewq_egress

// ===== rtl/ewq_pkg.sv
/*
  Shared constants and types for the egress arbiter and output queue.
  Assumes one system clock; register offsets are byte addresses.
*/
package ewq_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int PRIO_N  = 4;
  localparam int QDEPTH  = 8;
  localparam int PAY_W   = 32;
  localparam int WGT_W   = 8;
  localparam int WM_W    = 4;
  localparam int QCNT_W  = 4;
  localparam int ADR_W   = 8;
  localparam int DAT_W   = 32;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [ADR_W-1:0] OFS_WRR0  = 8'h00;
  localparam logic [ADR_W-1:0] OFS_WRR1  = 8'h04;
  localparam logic [ADR_W-1:0] OFS_WRR2  = 8'h08;
  localparam logic [ADR_W-1:0] OFS_WRR3  = 8'h0c;
  localparam logic [ADR_W-1:0] OFS_WM    = 8'h10;
  localparam logic [ADR_W-1:0] OFS_STAT  = 8'h14;
  localparam int               BIT_EN    = 0;
  localparam int               BIT_UC    = 1;
  localparam int               WGT_LSB   = 8;
  localparam int               WM0_LSB   = 0;
  localparam int               WM1_LSB   = 4;
  localparam int               WM2_LSB   = 8;
  localparam int               STAT_FREE = 0;
  localparam int               STAT_RTY  = 4;
  localparam int               STAT_PD   = 5;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [WM_W-1:0]  WM0_RST    = 4'h3;
  localparam logic [WM_W-1:0]  WM1_RST    = 4'h2;
  localparam logic [WM_W-1:0]  WM2_RST    = 4'h1;
  localparam int               RR_PTR_RST = 0;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]       prio;
    logic [PAY_W-1:0] pay;
  } ewq_pkt_t;
  typedef struct packed {
    logic             en;
    logic             uc;
    logic [WGT_W-1:0] wgt;
  } ewq_wrr_t;
  localparam ewq_wrr_t WRR_RST = '{en: 1'b0, uc: 1'b0, wgt: 8'h00};
  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_WAIT} ewq_tx_t;
endpackage

// ===== tb/ewq_link_model.sv
/*
  Link partner model: takes offered packets, answers ack or retry.
  Assumes core_clk_i shared with the egress port.
*/
`timescale 1ns/100ps
module ewq_link_model
  import ewq_pkg::*;
(
  input  wire logic     core_clk_i,
  input  wire logic     rst_i,
  input  wire logic     run_i,
  input  wire logic     tx_valid_i,
  input  wire ewq_pkt_t tx_pkt_i,
  output logic          tx_ready_o,
  output logic          tx_ack_o,
  output logic          tx_retry_o
);
  // ----------------------------------------------------------------
  // Take, wait, answer
  // ----------------------------------------------------------------
  logic [PAY_W-1:0] got[$];
  int               retry_left;
  logic             busy_r;
  logic [1:0]       dly_r;
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_ready_o <= 1'b0;
      tx_ack_o   <= 1'b0;
      tx_retry_o <= 1'b0;
      busy_r     <= 1'b0;
      dly_r      <= 2'h0;
    end else begin
      tx_ack_o   <= 1'b0;
      tx_retry_o <= 1'b0;
      if (tx_valid_i && tx_ready_o) begin
        got.push_back(tx_pkt_i.pay);
        busy_r     <= 1'b1;
        tx_ready_o <= 1'b0;
        dly_r      <= 2'h2;
      end else if (busy_r && dly_r != 2'h0) begin
        dly_r <= dly_r - 2'h1;
      end else if (busy_r) begin
        busy_r <= 1'b0;
        if (retry_left > 0) begin
          tx_retry_o <= 1'b1;
          retry_left <= retry_left - 1;
        end else begin
          tx_ack_o <= 1'b1;
        end
      end else begin
        tx_ready_o <= run_i;
      end
    end
  end
endmodule // ewq_link_model

// ===== tb/tb.sv
/*
  Self-checking bench for the egress arbiter and output queue.
  Assumes the link model answers the transmit side.
*/
`timescale 1ns/100ps
module tb
  import ewq_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int NI = 4;
  logic             core_clk_i, rst_i, reg_we_i, reg_re_i, pd, run, rdy, ack, rty;
  logic [ADR_W-1:0] reg_addr_i;
  logic [DAT_W-1:0] reg_wdata_i, rdata, d;
  logic [NI:0]      src_req_i, src_grant_o;
  ewq_pkt_t [NI:0]  src_pkt_i;
  logic             queue_full_o, tx_valid_o;
  ewq_pkt_t         tx_pkt_o;
  int               n_errors, compares, gs[$];
  ewq_egress #(.N_IN(NI)) u_ewq_egress (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(rdata), .src_req_i(src_req_i), .src_pkt_i(src_pkt_i), .src_grant_o(src_grant_o),
    .queue_full_o(queue_full_o), .port_power_down_i(pd), .tx_valid_o(tx_valid_o),
    .tx_pkt_o(tx_pkt_o), .tx_ready_i(rdy), .tx_ack_i(ack), .tx_retry_i(rty));
  ewq_link_model u_link (.core_clk_i(core_clk_i), .rst_i(rst_i), .run_i(run),
    .tx_valid_i(tx_valid_o), .tx_pkt_i(tx_pkt_o), .tx_ready_o(rdy), .tx_ack_o(ack), .tx_retry_o(rty));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task summarize;
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [DAT_W-1:0] seen, input logic [DAT_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] v);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_we_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_we_i <= 1'b0;
  endtask
  task rd(input logic [ADR_W-1:0] a);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_re_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_re_i <= 1'b0;
    @(negedge core_clk_i);
    d = rdata;
  endtask
  task idle;
    for (int i = 0; i < 100; i++) begin
      rd(OFS_STAT);
      if (d[3:0] === 4'h8 && tx_valid_o === 1'b0) break;
    end
    chk(DAT_W'(d[3:0]), 32'h8);
  endtask
  task send(input int s, input logic [1:0] p, input logic [PAY_W-1:0] v, input logic e);
    logic g;
    g = 1'b0;
    @(posedge core_clk_i);
    src_pkt_i[s] <= '{prio: p, pay: v};
    src_req_i[s] <= 1'b1;
    for (int i = 0; i < 4 && !g; i++) begin
      @(negedge core_clk_i);
      if (src_grant_o[s] === 1'b1) g = 1'b1;
      else @(posedge core_clk_i);
    end
    if (g) @(posedge core_clk_i);
    src_req_i[s] <= 1'b0;
    chk(DAT_W'(g), DAT_W'(e));
  endtask
  task run_req(input logic [NI:0] m, input int n);
    gs.delete();
    @(posedge core_clk_i);
    src_req_i <= m;
    for (int i = 0; i < 400 && gs.size() < n; i++) begin
      @(negedge core_clk_i);
      for (int s = 0; s <= NI; s++) if (src_grant_o[s] === 1'b1) gs.push_back(s);
    end
    @(posedge core_clk_i);
    src_req_i <= '0;
  endtask
  task set_pkt(input int s, input logic [1:0] p);
    @(posedge core_clk_i);
    src_pkt_i[s] <= '{prio: p, pay: PAY_W'(s)};
  endtask
  task wrr(input logic [DAT_W-1:0] cfg, input logic [NI:0] m, input int em);
    int c;
    c = 0;
    wr(OFS_WRR3, cfg);
    set_pkt(0, 2'h3);
    set_pkt(NI, 2'h3);
    run_req(m, 6);
    foreach (gs[i]) if (gs[i] == NI) c++;
    chk(DAT_W'(c), DAT_W'(em));
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    rd(OFS_WM);
    chk(d, 32'h123);
    @(negedge core_clk_i);
    chk(rdata, 32'h0);
    wr(OFS_WM, 32'h134);
    rd(OFS_WM);
    chk(d, 32'h134);
    wr(OFS_WM, 32'h123);
    rd(OFS_WM);
    chk(d, 32'h123);
    rd(OFS_STAT);
    chk(d, 32'h8);
    rd(8'h20);
    chk(d, 32'h0);
  endtask
  task t_rr;
    set_pkt(1, 2'h0);
    set_pkt(2, 2'h0);
    set_pkt(NI, 2'h0);
    run_req(5'h16, 3);
    chk(DAT_W'(gs[0]), 32'h1);
    chk(DAT_W'(gs[1]), 32'h2);
    chk(DAT_W'(gs[2]), 32'h4);
    idle();
    set_pkt(0, 2'h1);
    set_pkt(3, 2'h2);
    run_req(5'h09, 1);
    chk(DAT_W'(gs[0]), 32'h3);
    idle();
  endtask
  task t_wm;
    int k;
    logic [11:0] eg;
    eg = 12'h55f;
    run = 1'b0;
    repeat (2) @(posedge core_clk_i);
    u_link.got.delete();
    for (int i = 0; i < 12; i++) send(0, 2'((i < 6) ? 0 : (i - 4) / 2), PAY_W'(i), eg[i]);
    chk(DAT_W'(queue_full_o), 32'h1);
    rd(OFS_STAT);
    chk(d, 32'h0);
    run = 1'b1;
    idle();
    chk(DAT_W'(u_link.got.size()), 32'h8);
    k = 0;
    for (int i = 0; i < 12; i++) if (eg[i]) begin
      chk(u_link.got[k], DAT_W'(i));
      k++;
    end
  endtask
  task t_retry;
    run = 1'b0;
    repeat (2) @(posedge core_clk_i);
    u_link.got.delete();
    send(0, 2'h0, 32'h20, 1'b1);
    send(0, 2'h1, 32'h21, 1'b1);
    send(0, 2'h1, 32'h22, 1'b1);
    send(0, 2'h0, 32'h23, 1'b1);
    u_link.retry_left = 1;
    run = 1'b1;
    idle();
    chk(DAT_W'(u_link.got.size()), 32'h5);
    chk(u_link.got[0], 32'h20);
    chk(u_link.got[1], 32'h21);
  endtask
  task t_pd;
    run = 1'b0;
    repeat (2) @(posedge core_clk_i);
    u_link.got.delete();
    send(1, 2'h0, 32'h30, 1'b1);
    send(1, 2'h0, 32'h31, 1'b1);
    @(posedge core_clk_i);
    pd <= 1'b1;
    rd(OFS_STAT);
    chk(d, 32'h28);
    for (int i = 0; i < 7; i++) send(1, 2'h0, PAY_W'(i), 1'b1);
    chk(DAT_W'(tx_valid_o), 32'h0);
    @(posedge core_clk_i);
    pd <= 1'b0;
    run = 1'b1;
    idle();
    chk(DAT_W'(u_link.got.size()), 32'h0);
  endtask
  task t_wrr;
    wrr(32'h1, 5'h11, 0);
    wrr(32'h3, 5'h11, 6);
    wrr(32'h101, 5'h11, 3);
    wrr(32'h201, 5'h11, 4);
    wrr(32'h203, 5'h11, 2);
    wrr(32'h101, 5'h10, 6);
    rd(OFS_WRR3);
    chk(d, 32'h101);
    idle();
    set_pkt(0, 2'h0);
    set_pkt(NI, 2'h0);
    run_req(5'h11, 6);
    chk(DAT_W'(gs[0] != gs[1] && gs[2] != gs[3]), 32'h1);
  endtask
  // ----------------------------------------------------------------
  // Clock, reset, sequence, watchdog
  // ----------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  initial begin
    n_errors = 0;
    compares = 0;
    rst_i = 1'b1;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    src_req_i = '0;
    src_pkt_i = '0;
    pd = 1'b0;
    run = 1'b1;
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_rr();
    t_wm();
    t_retry();
    t_pd();
    t_wrr();
    summarize();
  end
  initial begin
    #400000;
    n_errors++;
    summarize();
  end
endmodule // tb
